//--- hdl/dynamic_termination_control.sv
// Purpose: Termination on/off and nominal/write strength selection
// Assumes: Pins arrive unsynchronised; power-down state from local logic
// Notes:   Analog settling after each flop edge lies outside this logic
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// RULE1 - Dynamic switching enabled when either write-strength bit is set
// RULE2 - Nominal strength comes from config bits 9, 6 and 2
// RULE3 - Write strength comes from dynamic config bits 10 and 9
// RULE4 - Without writes, nominal strength; pin and latencies set on/off
// RULE5 - Turn-on and turn-off latency both equal write latency minus two
// RULE6 - Switch to write strength write latency minus two after write
// RULE7 - Chopped write returns to nominal four plus turn-off latency later
// RULE8 - Full write returns to nominal six plus turn-off latency later
// RULE9 - All write variants switch; burst from mode or per command
// RULE10 - Controller clears write-strength bits while the loop is off
// RULE11 - Controller holds the pin high at least four cycles
// RULE12 - Controller holds pin four or six cycles after write
// RULE13 - New strength valid 0.3 to 0.7 clock periods after latency
// RULE14 - Asynchronous timing in precharge power-down with loop frozen
// RULE15 - Asynchronous mode skips the additive latency
// RULE16 - Asynchronous on and off within 2 to 8.5 ns; logic takes one 20 ns cycle after synchronising
// RULE17 - Pin receiver stays live in power-down; no writes there
// RULE18 - Synchronous latencies include the additive latency
// RULE19 - Self-refresh forces termination off and ignores the pin
module dynamic_termination_control (
  input  wire logic        REF_CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic        TERM_PIN_IN,
  input  wire logic        WRITE_CMD_IN,
  input  wire logic        WRITE_CHOP_IN,
  input  wire logic        PRECHARGE_PD_IN,
  input  wire logic        SELF_REFRESH_IN,
  output logic             TERM_EN_OUT,
  output logic [2:0]       TERM_STRENGTH_OUT,
  output logic             TERM_WR_SEL_OUT,
  input  wire logic [7:0]  AWADDR_IN,
  input  wire logic        AWVALID_IN,
  output logic             AWREADY_OUT,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic [3:0]  WSTRB_IN,
  input  wire logic        WVALID_IN,
  output logic             WREADY_OUT,
  output logic [1:0]       BRESP_OUT,
  output logic             BVALID_OUT,
  input  wire logic        BREADY_IN,
  input  wire logic [7:0]  ARADDR_IN,
  input  wire logic        ARVALID_IN,
  output logic             ARREADY_OUT,
  output logic [31:0]      RDATA_OUT,
  output logic [1:0]       RRESP_OUT,
  output logic             RVALID_OUT,
  input  wire logic        RREADY_IN
);
  localparam int ASYNC_DLY = term_ctl_pkg::ASYNC_MIN_CYC;

  logic [31:0] term_cfg_r;
  logic [31:0] dyn_cfg_r;
  logic [31:0] pd_cfg_r;
  logic [31:0] lat_cfg_r;
  logic [2:0]  sync1_r;
  logic [2:0]  sync2_r;
  logic        odt_s;
  logic        wr_s;
  logic        chop_s;
  logic [term_ctl_pkg::HIST_DEPTH-1:0] hist_r;
  logic [2:0]  rtt_nom;
  logic [1:0]  rtt_wr;
  logic        dyn_en;
  logic        async_mode;
  logic [4:0]  wl;
  logic [4:0]  lat;
  logic        wr_go;
  logic        chop_now;
  logic        wr_act_r;
  logic        chop_r;
  logic [4:0]  wr_cnt_r;
  logic [4:0]  wr_end;
  logic        sel_nxt;
  logic        on_nxt;
  logic [2:0]  str_nxt;
  logic        term_on_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_map;
  logic        rd_map;
  logic [31:0] rd_val;

  // Pin synchroniser; first stage feeds only the second
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {WRITE_CHOP_IN, WRITE_CMD_IN, TERM_PIN_IN};
      sync2_r <= sync1_r;
    end
  end
  assign odt_s  = sync2_r[0];
  assign wr_s   = sync2_r[1];
  assign chop_s = sync2_r[2];

  // Strength fields and mode decode
  // RULE2 nominal strength bits
  assign rtt_nom = {term_cfg_r[term_ctl_pkg::NOM_B9], term_cfg_r[term_ctl_pkg::NOM_B6],
                    term_cfg_r[term_ctl_pkg::NOM_B2]};
  // RULE3 write strength bits
  assign rtt_wr = {dyn_cfg_r[term_ctl_pkg::WR_B10], dyn_cfg_r[term_ctl_pkg::WR_B9]};
  // RULE1 dynamic switch enable
  assign dyn_en = (rtt_wr != 2'h0);
  // RULE14 frozen loop selects async timing
  assign async_mode = PRECHARGE_PD_IN & ~pd_cfg_r[term_ctl_pkg::PD_DLL];

  // RULE18 additive latency included
  assign wl = {1'b0, lat_cfg_r[term_ctl_pkg::CWL_LSB +: 4]} + {1'b0, lat_cfg_r[term_ctl_pkg::AL_LSB +: 4]};
  // RULE5 latency is write latency minus two
  // Clamped to one cycle; smaller settings are not legal
  assign lat = (wl > term_ctl_pkg::LAT_OFFSET + 5'h01) ? wl - term_ctl_pkg::LAT_OFFSET : 5'h01;

  // RULE17 writes are not decoded in power-down
  assign wr_go = wr_s & dyn_en & ~PRECHARGE_PD_IN & ~SELF_REFRESH_IN;

  // RULE9 burst from mode setting or per command
  always_comb begin
    chop_now = 1'b0;
    unique case (lat_cfg_r[term_ctl_pkg::BST_LSB +: 2])
      term_ctl_pkg::BURST_FULL: chop_now = 1'b0;
      term_ctl_pkg::BURST_OTF:  chop_now = chop_s;
      term_ctl_pkg::BURST_CHOP: chop_now = 1'b1;
      default:                  chop_now = 1'b0;
    endcase
  end

  // RULE7 chopped return point
  // RULE8 full return point
  assign wr_end = lat + (chop_r ? term_ctl_pkg::CHOP_EXTRA : term_ctl_pkg::FULL_EXTRA);

  // Pin history; sample k sits in bit k cycles after capture
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN || SELF_REFRESH_IN) begin
      hist_r <= '0;
    end else begin
      hist_r <= {hist_r[term_ctl_pkg::HIST_DEPTH-2:0], odt_s};
    end
  end

  // Cycle count since the last registered write
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      wr_act_r <= 1'b0;
      chop_r   <= 1'b0;
      wr_cnt_r <= 5'h00;
    end else if (wr_go) begin
      wr_act_r <= 1'b1;
      chop_r   <= chop_now;
      wr_cnt_r <= 5'h01;
    end else if (wr_act_r && (wr_cnt_r == wr_end || !dyn_en || SELF_REFRESH_IN)) begin
      wr_act_r <= 1'b0;
      wr_cnt_r <= 5'h00;
    end else if (wr_act_r) begin
      wr_cnt_r <= wr_cnt_r + 5'h01;
    end
  end

  // Next strength select and on state
  always_comb begin
    sel_nxt = TERM_WR_SEL_OUT;
    // RULE6 switch to write strength
    if (wr_act_r && wr_cnt_r == lat) begin
      sel_nxt = 1'b1;
    end
    // RULE7 end of write strength
    if (wr_act_r && wr_cnt_r == wr_end) begin
      sel_nxt = 1'b0;
    end
    if (!dyn_en || SELF_REFRESH_IN) begin
      sel_nxt = 1'b0;
    end
    // RULE4 nominal unless a write selects
    str_nxt = sel_nxt ? {1'b0, rtt_wr} : rtt_nom;
    // RULE15 async path skips latency
    // RULE16 window is shorter than one cycle; one cycle is used
    if (async_mode) begin
      on_nxt = odt_s;
    end else begin
      on_nxt = hist_r[lat - 5'h01];
    end
    // RULE19 forced off in self-refresh
    if (SELF_REFRESH_IN) begin
      on_nxt = 1'b0;
    end
  end

  // Output flops
  // RULE13 strength changes at the edge ending the latency
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      TERM_WR_SEL_OUT   <= 1'b0;
      TERM_STRENGTH_OUT <= 3'h0;
      TERM_EN_OUT       <= 1'b0;
      term_on_r         <= 1'b0;
    end else begin
      TERM_WR_SEL_OUT   <= sel_nxt;
      TERM_STRENGTH_OUT <= str_nxt;
      term_on_r         <= on_nxt;
      TERM_EN_OUT       <= on_nxt & (str_nxt != 3'h0); // Zero code means off
    end
  end

  // Bus address decode
  assign wr_map = (aw_addr_r == term_ctl_pkg::ADDR_TERM_CFG) || (aw_addr_r == term_ctl_pkg::ADDR_DYN_CFG) ||
                  (aw_addr_r == term_ctl_pkg::ADDR_PD_CFG) || (aw_addr_r == term_ctl_pkg::ADDR_LAT_CFG);
  always_comb begin
    rd_map = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (ARADDR_IN)
      term_ctl_pkg::ADDR_TERM_CFG: rd_val = term_cfg_r;
      term_ctl_pkg::ADDR_DYN_CFG:  rd_val = dyn_cfg_r;
      term_ctl_pkg::ADDR_PD_CFG:   rd_val = pd_cfg_r;
      term_ctl_pkg::ADDR_LAT_CFG:  rd_val = lat_cfg_r;
      term_ctl_pkg::ADDR_STATUS: begin
        rd_val[term_ctl_pkg::ST_ON]   = term_on_r;
        rd_val[term_ctl_pkg::ST_WSEL] = TERM_WR_SEL_OUT;
        rd_val[term_ctl_pkg::ST_ASYN] = async_mode;
      end
      default: rd_map = 1'b0;
    endcase
  end

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Write address and data taken in either order
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else if (aw_got_r && w_got_r && !BVALID_OUT) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
    end else begin
      if (AWVALID_IN && AWREADY_OUT) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= AWADDR_IN;
      end
      if (WVALID_IN && WREADY_OUT) begin
        w_got_r  <= 1'b1;
        w_data_r <= WDATA_IN;
        w_strb_r <= WSTRB_IN;
      end
    end
  end

  // Ready stays low while a channel item is held
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      AWREADY_OUT <= 1'b0;
      WREADY_OUT  <= 1'b0;
    end else begin
      AWREADY_OUT <= !aw_got_r && !(AWVALID_IN && AWREADY_OUT) && !BVALID_OUT;
      WREADY_OUT  <= !w_got_r && !(WVALID_IN && WREADY_OUT) && !BVALID_OUT;
    end
  end

  // Register update and write response
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      term_cfg_r <= term_ctl_pkg::TERM_CFG_RST;
      dyn_cfg_r  <= term_ctl_pkg::DYN_CFG_RST;
      pd_cfg_r   <= term_ctl_pkg::PD_CFG_RST;
      lat_cfg_r  <= term_ctl_pkg::LAT_CFG_RST;
      BVALID_OUT <= 1'b0;
      BRESP_OUT  <= term_ctl_pkg::RESP_OKAY;
    end else if (aw_got_r && w_got_r && !BVALID_OUT) begin
      BVALID_OUT <= 1'b1;
      BRESP_OUT  <= wr_map ? term_ctl_pkg::RESP_OKAY : term_ctl_pkg::RESP_SLVERR;
      unique case (aw_addr_r)
        term_ctl_pkg::ADDR_TERM_CFG: term_cfg_r <= merge(term_cfg_r, w_data_r, w_strb_r);
        term_ctl_pkg::ADDR_DYN_CFG:  dyn_cfg_r <= merge(dyn_cfg_r, w_data_r, w_strb_r);
        term_ctl_pkg::ADDR_PD_CFG:   pd_cfg_r <= merge(pd_cfg_r, w_data_r, w_strb_r);
        term_ctl_pkg::ADDR_LAT_CFG:  lat_cfg_r <= merge(lat_cfg_r, w_data_r, w_strb_r);
        default: ;
      endcase
    end else if (BVALID_OUT && BREADY_IN) begin
      BVALID_OUT <= 1'b0;
    end
  end

  // Read channel; one read outstanding
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      ARREADY_OUT <= 1'b0;
      RVALID_OUT  <= 1'b0;
      RDATA_OUT   <= 32'h0000_0000;
      RRESP_OUT   <= term_ctl_pkg::RESP_OKAY;
    end else if (ARVALID_IN && ARREADY_OUT) begin
      ARREADY_OUT <= 1'b0;
      RVALID_OUT  <= 1'b1;
      RDATA_OUT   <= rd_val;
      RRESP_OUT   <= rd_map ? term_ctl_pkg::RESP_OKAY : term_ctl_pkg::RESP_SLVERR;
    end else if (RVALID_OUT && RREADY_IN) begin
      RVALID_OUT <= 1'b0;
    end else begin
      ARREADY_OUT <= !RVALID_OUT;
    end
  end

  // Checks
  sequence s_wr_start;
    wr_go;
  endsequence
  sequence s_cnt_walk;
    wr_cnt_r == 5'h01 ##1 (wr_go || wr_cnt_r == 5'h02);
  endsequence

  a_write_count_walk: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // RULE9
    s_wr_start |=> s_cnt_walk) else $error("Write count did not start");
  a_write_sel_rise: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // RULE6
    $rose(TERM_WR_SEL_OUT) |-> $past(wr_cnt_r) == $past(lat)) else $error("Write strength at wrong cycle");
  a_write_sel_fall: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // RULE8
    $fell(TERM_WR_SEL_OUT) && $past(dyn_en) && !$past(SELF_REFRESH_IN) |->
      $past(wr_cnt_r) == $past(lat) + ($past(chop_r) ? 5'h04 : 5'h06)) else $error("Nominal return late or early");
  a_dyn_off_nominal: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // RULE1
    !dyn_en |=> !TERM_WR_SEL_OUT) else $error("Write strength with dynamic off");
  a_write_strength: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // RULE3
    TERM_WR_SEL_OUT |-> TERM_STRENGTH_OUT == {1'b0, $past(rtt_wr)}) else $error("Write strength code wrong");
  a_nominal_strength: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // RULE2
    !TERM_WR_SEL_OUT |-> TERM_STRENGTH_OUT == $past(rtt_nom)) else $error("Nominal strength code wrong");
  a_async_follow: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // RULE16
    async_mode && !SELF_REFRESH_IN && $changed(odt_s) |-> ##ASYNC_DLY term_on_r == $past(odt_s, 1))
    else $error("Async termination not prompt");
  a_self_refresh_off: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // RULE19
    SELF_REFRESH_IN[*2] |-> !TERM_EN_OUT && !term_on_r) else $error("Termination on in self-refresh");
  a_sync_latency: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // RULE5
    !async_mode && !SELF_REFRESH_IN && $stable(lat) && $rose(hist_r[0]) && lat == 5'h03 |->
      ##3 term_on_r) else $error("Sync turn-on latency wrong");
  a_resp_hold: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT)) else $error("Write response dropped");
endmodule

//--- hdl/term_ctl_pkg.sv
// Purpose: Shared constants for the termination control block
// Assumes: 50 MHz clock, AXI4-Lite register access, 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package term_ctl_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_TERM_CFG = 8'h00;
  localparam logic [7:0] ADDR_DYN_CFG  = 8'h04;
  localparam logic [7:0] ADDR_PD_CFG   = 8'h08;
  localparam logic [7:0] ADDR_LAT_CFG  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  // Field positions
  localparam int NOM_B2  = 2;
  localparam int NOM_B6  = 6;
  localparam int NOM_B9  = 9;
  localparam int WR_B9   = 9;
  localparam int WR_B10  = 10;
  localparam int PD_DLL  = 12;
  localparam int CWL_LSB = 0;
  localparam int AL_LSB  = 4;
  localparam int BST_LSB = 8;
  localparam int ST_ON   = 0;
  localparam int ST_WSEL = 1;
  localparam int ST_ASYN = 2;
  // Reset values
  localparam logic [31:0] TERM_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] DYN_CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] PD_CFG_RST   = 32'h0000_0000;
  localparam logic [31:0] LAT_CFG_RST  = 32'h0000_0005;
  // Latency arithmetic, in clock cycles
  localparam logic [4:0] LAT_OFFSET = 5'h02;
  localparam logic [4:0] CHOP_EXTRA = 5'h04;
  localparam logic [4:0] FULL_EXTRA = 5'h06;
  localparam int         HIST_DEPTH = 32;
  // Asynchronous delay window and change skew
  localparam int CLK_PERIOD_PS = 20000;
  localparam int ASYNC_MIN_PS  = 2000;
  localparam int ASYNC_MAX_PS  = 8500;
  localparam int ASYNC_MIN_RAW = (ASYNC_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ASYNC_MAX_RAW = ASYNC_MAX_PS / CLK_PERIOD_PS;
  localparam int ASYNC_MIN_CYC = (ASYNC_MIN_RAW < 1) ? 1 : ASYNC_MIN_RAW;
  localparam int ASYNC_MAX_CYC = (ASYNC_MAX_RAW < 1) ? 1 : ASYNC_MAX_RAW;
  localparam int SKEW_MIN_TENTHS = 3;
  localparam int SKEW_MAX_TENTHS = 7;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Burst selection
  typedef enum logic [1:0] {
    BURST_FULL = 2'b00,
    BURST_OTF  = 2'b01,
    BURST_CHOP = 2'b10
  } burst_mode_t;
endpackage

//--- test/dynamic_termination_control_tb.sv
// Purpose: Self-checking bench for termination control
// Assumes: Two-edge pin synchronisers ahead of the latency logic
// Notes:   Delays are counted from the edge that drives the pin
`timescale 1ns/1ps
module dynamic_termination_control_tb;
  localparam int PIN_OFS = 3;
  localparam int WR_OFS = 2;
  localparam int NEVER = 40;
  localparam logic [7:0] A_NOM = term_ctl_pkg::ADDR_TERM_CFG;
  localparam logic [7:0] A_DYN = term_ctl_pkg::ADDR_DYN_CFG;
  localparam logic [7:0] A_PD = term_ctl_pkg::ADDR_PD_CFG;
  localparam logic [7:0] A_LAT = term_ctl_pkg::ADDR_LAT_CFG;
  localparam logic [7:0] A_ST = term_ctl_pkg::ADDR_STATUS;
  localparam logic [1:0] OK = term_ctl_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = term_ctl_pkg::RESP_SLVERR;
  logic        clk = 1'b0;
  logic        rst;
  logic        pd;
  logic        sr;
  logic        pin, wr, chop, en, wrsel, awready, wready, bvalid, arready, rvalid;
  logic [2:0]  code;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          n_mismatch = 0, n_checks = 0, cycles = 0;
  dynamic_termination_control uut (
    .REF_CLK_IN(clk), .SYS_RST_IN(rst), .TERM_PIN_IN(pin), .WRITE_CMD_IN(wr), .WRITE_CHOP_IN(chop),
    .PRECHARGE_PD_IN(pd), .SELF_REFRESH_IN(sr), .TERM_EN_OUT(en), .TERM_STRENGTH_OUT(code),
    .TERM_WR_SEL_OUT(wrsel), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
    .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp),
    .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
    .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready)
  );
  mem_ctl_model ctl (.clk_in(clk), .pd_in(pd), .pin_out(pin), .wr_out(wr), .chop_out(chop));
  // 50 MHz clock
  always #10 clk = ~clk;
  // Watchdog so a stuck handshake still ends the run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic results();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Count edges until the output reaches v; gives up at NEVER
  task automatic dly(input logic ws, input logic v, input int exp);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((ws ? wrsel : en) !== v && n < NEVER);
    chk(32'(n), 32'(exp));
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, dd;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 1'b0;
    dd = 1'b0;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awready && !ad) awvalid <= 1'b0;
      if (wready && !dd) wvalid <= 1'b0;
      ad = ad | awready;
      dd = dd | wready;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask
  // Reset values, unmapped accesses, read-back of spare bits
  task automatic t_regs();
    logic [7:0]  ad [5] = '{A_NOM, A_DYN, A_PD, A_LAT, A_ST};
    logic [31:0] rv [5] = '{term_ctl_pkg::TERM_CFG_RST, term_ctl_pkg::DYN_CFG_RST,
                            term_ctl_pkg::PD_CFG_RST, term_ctl_pkg::LAT_CFG_RST, 32'h0000_0000};
    for (int i = 0; i < 5; i++) axi_rd(ad[i], rv[i], OK);
    axi_rd(8'h14, 32'h0000_0000, ERR);
    axi_wr(8'h14, 32'h0000_0204, ERR);
    axi_wr(A_PD, 32'h0000_1234, OK);
    axi_rd(A_PD, 32'h0000_1234, OK);
    // Only the low byte lane may change
    wstrb <= 4'h1;
    axi_wr(A_PD, 32'h0000_56ff, OK);
    wstrb <= 4'hf;
    axi_rd(A_PD, 32'h0000_12ff, OK);
    axi_wr(A_PD, 32'h0000_0000, OK);
  endtask
  // Pin-driven on/off across latencies and nominal codes
  task automatic t_sync();
    logic [3:0]  cw [5] = '{4'h5, 4'h7, 4'h5, 4'h2, 4'h5};
    logic [3:0]  al [5] = '{4'h0, 4'h0, 4'h3, 4'h0, 4'h0};
    logic [31:0] nm [5] = '{32'h0000_0004, 32'h0000_0240, 32'h0000_0204, 32'h0000_0044, 32'h0000_0000};
    logic [2:0]  nc [5] = '{3'h1, 3'h6, 3'h5, 3'h3, 3'h0};
    int          lat;
    for (int i = 0; i < 5; i++) begin
      lat = int'(cw[i]) + int'(al[i]) - 2;
      if (lat < 1) lat = 1;
      axi_wr(A_LAT, {24'h00_0000, al[i], cw[i]}, OK);
      axi_wr(A_NOM, nm[i], OK);
      ctl.pin_set(1'b1);
      dly(1'b0, 1'b1, nc[i] === 3'h0 ? NEVER : lat + PIN_OFS); // turn-on delay
      chk(32'(code), 32'(nc[i])); // nominal code
      ctl.pin_set(1'b0);
      if (nc[i] !== 3'h0) dly(1'b0, 1'b0, lat + PIN_OFS); // turn-off delay
    end
  endtask
  // Write strength switching for every burst selection
  task automatic t_dyn();
    logic [1:0] bs [6] = '{2'h0, 2'h2, 2'h1, 2'h1, 2'h3, 2'h0};
    logic       ch [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic       b4 [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [1:0] wb [6] = '{2'h2, 2'h1, 2'h3, 2'h2, 2'h1, 2'h0};
    axi_wr(A_NOM, 32'h0000_0200, OK);
    for (int i = 0; i < 6; i++) begin
      axi_wr(A_LAT, {22'h00_0000, bs[i], 8'h05}, OK);
      axi_wr(A_DYN, {21'h00_0000, wb[i], 9'h000}, OK);
      ctl.pin_set(1'b1);
      dly(1'b0, 1'b1, 3 + PIN_OFS); // pin sets timing
      ctl.wr_pulse(ch[i], b4[i]);
      dly(1'b1, 1'b1, wb[i] === 2'h0 ? NEVER : 3 + WR_OFS); // switch delay
      if (wb[i] !== 2'h0) begin
        chk(32'(code), {29'h0000_0000, 1'b0, wb[i]}); // write code
        dly(1'b1, 1'b0, b4[i] ? 4 : 6); // write span
        chk(32'(code), 32'h0000_0004); // back to nominal
      end
      ctl.pin_set(1'b0);
      dly(1'b0, 1'b0, 3 + PIN_OFS); // turn-off delay
    end
  endtask
  // Power-down with the loop frozen, then kept running
  task automatic t_async();
    axi_wr(A_LAT, 32'h0000_0035, OK);
    axi_wr(A_NOM, 32'h0000_0004, OK);
    axi_wr(A_DYN, 32'h0000_0000, OK); // write bits cleared
    for (int i = 0; i < 2; i++) begin
      axi_wr(A_PD, i ? 32'h0000_1000 : 32'h0000_0000, OK);
      pd <= 1'b1;
      ctl.pin_set(1'b1);
      dly(1'b0, 1'b1, i ? 6 + PIN_OFS : term_ctl_pkg::ASYNC_MIN_CYC + 2); // on
      if (i == 0) axi_rd(A_ST, 32'h0000_0005, OK); // mode status
      ctl.pin_set(1'b0);
      dly(1'b0, 1'b0, i ? 6 + PIN_OFS : term_ctl_pkg::ASYNC_MIN_CYC + 2); // off delay
      @(posedge clk);
      pd <= 1'b0;
    end
  endtask
  // Self-refresh drops termination and ignores the pin
  task automatic t_sr();
    ctl.pin_set(1'b1);
    dly(1'b0, 1'b1, 6 + PIN_OFS); // turn-on delay
    @(posedge clk);
    sr <= 1'b1;
    dly(1'b0, 1'b0, 1); // forced off
    ctl.pin_set(1'b0);
    ctl.pin_set(1'b1);
    dly(1'b0, 1'b1, NEVER); // pin ignored
    @(posedge clk);
    sr <= 1'b0;
    ctl.pin_set(1'b0);
  endtask
  // Reset for two edges, then the scenarios
  initial begin
    rst <= 1'b1;
    pd <= 1'b0;
    sr <= 1'b0;
    awaddr <= 8'h00;
    araddr <= 8'h00;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    wdata <= 32'h0000_0000;
    wstrb <= 4'hf;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_sync();
    t_dyn();
    t_async();
    t_sr();
    results();
  end
endmodule

//--- test/mem_ctl_model.sv
// Purpose: Controller model driving termination pin and writes
// Assumes: Calls start at a rising edge; drives by non-blocking assignment
// Notes:   Pin release waits out every open hold window
`timescale 1ns/1ps
module mem_ctl_model (
  input  wire logic clk_in,
  input  wire logic pd_in,
  output logic      pin_out,
  output logic      wr_out,
  output logic      chop_out
);
  int cyc;
  int hold_until;
  // Idle levels at power-up
  initial begin
    cyc = 0;
    hold_until = 0;
    pin_out = 1'b0;
    wr_out = 1'b0;
    chop_out = 1'b0;
  end
  // Edge count for the hold windows
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
  end
  task automatic pin_set(input logic v);
    @(posedge clk_in);
    while (!v && cyc < hold_until) @(posedge clk_in);
    pin_out <= v;
    if (v && !pin_out) hold_until = cyc + 4;
  endtask
  // hold after write, none in power-down
  task automatic wr_pulse(input logic chop, input logic bc4);
    @(posedge clk_in);
    if (!pd_in) begin
      wr_out <= 1'b1;
      chop_out <= chop;
      if (pin_out && hold_until < cyc + (bc4 ? 4 : 6)) hold_until = cyc + (bc4 ? 4 : 6);
    end
    // Command lasts one cycle; only this task drives it
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask
endmodule
